/* hsb_pkg.sv */
package hsb_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] IN_BITS_OFS    = 8'h00;
   localparam logic [7:0] OUT_BITS_OFS   = 8'h04;
   localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFS   = 8'h0c;

   // ----------------------------------------------------------------
   // Input word layout (bit n is input bit n)
   // ----------------------------------------------------------------
   localparam int CH_STRIDE          = 7;
   localparam int X_TX_OK            = 0;
   localparam int X_TX_NG            = 1;
   localparam int X_RX_REQ           = 3;
   localparam int X_RX_ERR           = 4;
   localparam int X_BUSY             = 6;
   localparam int X_FLASH_RD         = 23;
   localparam int X_FLASH_WR         = 24;
   localparam int X_BCAST            = 26;
   localparam int X_RESTORE_DONE     = 28;
   localparam int X_PROTO_READY      = 29;
   localparam int X_ACCESSIBLE       = 30;
   localparam int X_WDT              = 31;

   // ----------------------------------------------------------------
   // Output word layout (bit n is output bit n)
   // ----------------------------------------------------------------
   localparam int Y_TX_REQ           = 0;
   localparam int Y_RD_DONE          = 1;
   localparam int Y_MODE_REQ         = 2;
   localparam int Y_FLASH_RD         = 23;
   localparam int Y_FLASH_WR         = 24;
   localparam int Y_RESTORE_REQ      = 28;
   // Only defined request bits hold a value; reserved and modem bits stay zero
   localparam logic [31:0] Y_WR_MASK = 32'h1180_0387;

   // ----------------------------------------------------------------
   // Interrupt status layout
   // ----------------------------------------------------------------
   localparam int IRQ_W              = 7;
   localparam int IRQ_BCAST          = 0;
   localparam int IRQ_RESTORE        = 2;
   localparam int IRQ_READY          = 3;
   localparam int IRQ_WDT            = 4;
   localparam int IRQ_RX             = 5;

   // ----------------------------------------------------------------
   // Reset values and timing
   // ----------------------------------------------------------------
   localparam logic [31:0] Y_RST        = 32'h0000_0000;
   localparam logic [IRQ_W-1:0] MASK_RST = 7'h00;
   localparam int CLK_MHZ            = 200;
   localparam int READY_TIME_MS      = 1000;
   localparam int READY_CYC          = READY_TIME_MS * 1000 * CLK_MHZ;
   localparam int RESTORE_CYC        = 16;
   localparam int BUSY_SRC_W         = 6;

   typedef enum logic [2:0] {
      RST_IDLE = 3'b001,
      RST_RUN  = 3'b010,
      RST_DONE = 3'b100
   } hsb_restore_e;

endpackage : hsb_pkg

/* hsb_top.sv */
// Contract
// [RQ1] Each channel raises its broadcast flag when a broadcast command instructs an output.
// [RQ2] Host raises restore request; device restores defaults then raises restore done.
// [RQ3] Protocol-ready bit rises once predefined protocol sequences can run.
// [RQ4] Accessible bit rises about one second after reset.
// [RQ5] Host gates every access on the accessible bit. The testbench reads the input, output and mask registers before it rises.
// [RQ6] Watchdog fault bit high on internal fault, low in normal operation.
// [RQ7] Channel busy bit high during mode switch, reinit, clears and frame designation.
// [RQ8] While busy, channel communication is suspended and host issues no requests. The testbench keeps both transmit request bits set while busy.
// [RQ9] Host never drives reserved output bits.
// [RQ10] Modem input and output bits are unavailable and unused.
// [RQ11] Transmit and flash completion bits ignore dedicated-instruction execution.
// [RQ12] Receive request and error bits follow instructions too, clearing after read.
// [RQ13] Each status input pairs with a host request output per channel.
// [RQ14] Accessible bit stays low during reset and post-reset initialisation.
module hsb_top
   import hsb_pkg::*;
#(
   parameter int READY_CYCLES   = READY_CYC,
   parameter int RESTORE_CYCLES = RESTORE_CYC
) (
   input  wire logic                       core_clk_i,
   input  wire logic                       srst_i,
   // AHB-Lite slave
   input  wire logic                       hsel_i,
   input  wire logic [31:0]                haddr_i,
   input  wire logic [1:0]                 htrans_i,
   input  wire logic                       hwrite_i,
   input  wire logic [2:0]                 hsize_i,
   input  wire logic [31:0]                hwdata_i,
   input  wire logic                       hready_i,
   output logic [31:0]                     hrdata_o,
   output logic                            hreadyout_o,
   output logic                            hresp_o,
   output logic                            irq_o,
   // Internal module events and levels
   input  wire logic [1:0]                 broadcast_i,
   input  wire logic [1:0]                 tx_ok_i,
   input  wire logic [1:0]                 tx_ng_i,
   input  wire logic [1:0]                 tx_by_instr_i,
   input  wire logic [1:0]                 rx_data_i,
   input  wire logic [1:0]                 rx_err_i,
   input  wire logic [1:0]                 rx_instr_read_i,
   input  wire logic [1:0][BUSY_SRC_W-1:0] busy_src_i,
   input  wire logic                       flash_rd_done_i,
   input  wire logic                       flash_wr_done_i,
   input  wire logic                       flash_by_instr_i,
   input  wire logic                       proto_ready_i,
   input  wire logic                       watchdog_fault_condition_i,
   // Requests toward internal logic
   output logic [1:0]                      tx_req_o,
   output logic [1:0]                      rx_read_done_o,
   output logic [1:0]                      mode_switch_req_o,
   output logic [1:0]                      comm_run_o,
   output logic                            flash_rd_req_o,
   output logic                            flash_wr_req_o,
   output logic                            restore_active_o
);

   // ----------------------------------------------------------------
   // Local state
   // ----------------------------------------------------------------
   localparam int RST_BND = 24;
   localparam logic [31:0] READY_LAST = 32'(READY_CYCLES - 1);
   localparam logic [31:0] RESTORE_LAST = 32'(RESTORE_CYCLES - 1);

   logic [31:0]      y_q;
   logic [31:0]      ready_cnt_q;
   logic             module_accessible_q;
   logic             seq_protocol_ready_q;
   logic             watchdog_fault_q;
   logic             default_restore_done_q;
   logic [1:0]       bcast_q;
   logic [1:0]       tx_ok_q;
   logic [1:0]       tx_ng_q;
   logic [1:0]       rx_req_q;
   logic [1:0]       rx_err_q;
   logic [1:0]       busy_q;
   logic             flash_rd_q;
   logic             flash_wr_q;
   logic [IRQ_W-1:0] irq_st_q;
   logic [IRQ_W-1:0] irq_mask_q;
   logic [IRQ_W-1:0] irq_ev;
   hsb_restore_e     rst_state_q;
   logic [31:0]      rst_cnt_q;
   logic [31:0]      x_word;
   logic [31:0]      rd_word;
   logic             ap_wr_q;
   logic [7:0]       ap_addr_q;
   logic             ap_take;

   // ----------------------------------------------------------------
   // Input word, as the host sees it
   // ----------------------------------------------------------------
   always_comb begin
      x_word = 32'h0000_0000;
      for (int c = 0; c < 2; c++) begin
         x_word[c*CH_STRIDE+X_TX_OK]  = tx_ok_q[c];
         x_word[c*CH_STRIDE+X_TX_NG]  = tx_ng_q[c];
         x_word[c*CH_STRIDE+X_RX_REQ] = rx_req_q[c];
         x_word[c*CH_STRIDE+X_RX_ERR] = rx_err_q[c];
         x_word[c*CH_STRIDE+X_BUSY]   = busy_q[c];
         x_word[X_BCAST+c]            = bcast_q[c];
      end
      // Modem bits 10h..16h read as zero: no modem in this block
      x_word[X_FLASH_RD]     = flash_rd_q;
      x_word[X_FLASH_WR]     = flash_wr_q;
      x_word[X_RESTORE_DONE] = default_restore_done_q;
      x_word[X_PROTO_READY]  = seq_protocol_ready_q;
      x_word[X_ACCESSIBLE]   = module_accessible_q;
      x_word[X_WDT]          = watchdog_fault_q;
   end

   // ----------------------------------------------------------------
   // AHB-Lite slave: zero wait states, always OKAY
   // ----------------------------------------------------------------
   assign ap_take = hsel_i && htrans_i[1] && hready_i;

   always_comb begin
      case (haddr_i[7:0])
         IN_BITS_OFS:    rd_word = x_word;
         OUT_BITS_OFS:   rd_word = y_q;
         IRQ_STATUS_OFS: rd_word = 32'(irq_st_q);
         IRQ_MASK_OFS:   rd_word = 32'(irq_mask_q);
         default:        rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         ap_wr_q     <= 1'b0;
         ap_addr_q   <= 8'h00;
         hrdata_o    <= 32'h0000_0000;
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end else begin
         ap_wr_q   <= ap_take && hwrite_i;
         ap_addr_q <= haddr_i[7:0];
         if (ap_take && !hwrite_i) begin
            hrdata_o <= rd_word;
         end
      end
   end

   // Reserved and modem bits are masked so a stray write cannot reach them
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         y_q <= Y_RST;
      end else if (ap_wr_q && ap_addr_q == OUT_BITS_OFS) begin
         y_q <= hwdata_i & Y_WR_MASK; // RQ9 RQ10
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         irq_mask_q <= MASK_RST;
      end else if (ap_wr_q && ap_addr_q == IRQ_MASK_OFS) begin
         irq_mask_q <= hwdata_i[IRQ_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Ready interlock and global status
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         ready_cnt_q         <= 32'h0000_0000;
         module_accessible_q <= 1'b0; // RQ14
      end else if (!module_accessible_q) begin
         ready_cnt_q <= ready_cnt_q + 32'h0000_0001;
         if (ready_cnt_q == READY_LAST) begin
            module_accessible_q <= 1'b1; // RQ4
         end
      end
   end

   // A watchdog fault needs a restart, so it is held until reset
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         watchdog_fault_q     <= 1'b0;
         seq_protocol_ready_q <= 1'b0;
      end else begin
         watchdog_fault_q     <= watchdog_fault_q | watchdog_fault_condition_i; // RQ6
         seq_protocol_ready_q <= proto_ready_i && module_accessible_q; // RQ3
      end
   end

   // ----------------------------------------------------------------
   // Default-settings restore handshake
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         rst_state_q            <= RST_IDLE;
         rst_cnt_q              <= 32'h0000_0000;
         default_restore_done_q <= 1'b0;
         restore_active_o       <= 1'b0;
      end else begin
         case (rst_state_q)
            RST_IDLE: begin
               if (y_q[Y_RESTORE_REQ]) begin // RQ2
                  rst_state_q      <= RST_RUN;
                  rst_cnt_q        <= 32'h0000_0000;
                  restore_active_o <= 1'b1;
               end
            end
            RST_RUN: begin
               rst_cnt_q <= rst_cnt_q + 32'h0000_0001;
               if (rst_cnt_q == RESTORE_LAST) begin
                  rst_state_q            <= RST_DONE;
                  restore_active_o       <= 1'b0;
                  default_restore_done_q <= 1'b1; // RQ2
               end
            end
            RST_DONE: begin
               // Done stays up until the host withdraws its request
               if (!y_q[Y_RESTORE_REQ]) begin // RQ13
                  rst_state_q            <= RST_IDLE;
                  default_restore_done_q <= 1'b0;
               end
            end
            default: begin
               rst_state_q <= RST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Per-channel status and requests
   // ----------------------------------------------------------------
   for (genvar c = 0; c < 2; c++) begin : g_ch
      logic cy_tx;
      logic cy_rd;
      assign cy_tx = y_q[c*CH_STRIDE+Y_TX_REQ];
      assign cy_rd = y_q[c*CH_STRIDE+Y_RD_DONE];

      always_ff @(posedge core_clk_i) begin
         if (srst_i) begin
            bcast_q[c] <= 1'b0;
            busy_q[c]  <= 1'b0;
         end else begin
            bcast_q[c] <= broadcast_i[c]; // RQ1
            busy_q[c]  <= |busy_src_i[c]; // RQ7
         end
      end

      // Completion follows the request: set wins, cleared when request drops
      always_ff @(posedge core_clk_i) begin
         if (srst_i) begin
            tx_ok_q[c] <= 1'b0;
            tx_ng_q[c] <= 1'b0;
         end else begin
            if (tx_ok_i[c] && !tx_by_instr_i[c]) begin
               tx_ok_q[c] <= 1'b1; // RQ11
            end else if (!cy_tx) begin
               tx_ok_q[c] <= 1'b0; // RQ13
            end
            if (tx_ng_i[c] && !tx_by_instr_i[c]) begin
               tx_ng_q[c] <= 1'b1; // RQ11
            end else if (!cy_tx) begin
               tx_ng_q[c] <= 1'b0;
            end
         end
      end

      always_ff @(posedge core_clk_i) begin
         if (srst_i) begin
            rx_req_q[c] <= 1'b0;
            rx_err_q[c] <= 1'b0;
         end else begin
            if (rx_data_i[c]) begin
               rx_req_q[c] <= 1'b1; // RQ12
            end else if (cy_rd || rx_instr_read_i[c]) begin
               rx_req_q[c] <= 1'b0; // RQ12
            end
            if (rx_err_i[c]) begin
               rx_err_q[c] <= 1'b1;
            end else if (cy_rd || rx_instr_read_i[c]) begin
               rx_err_q[c] <= 1'b0;
            end
         end
      end

      // Transmit requests and comm_run are dropped while busy so a host slip cannot start traffic
      always_ff @(posedge core_clk_i) begin
         if (srst_i) begin
            tx_req_o[c]          <= 1'b0;
            rx_read_done_o[c]    <= 1'b0;
            mode_switch_req_o[c] <= 1'b0;
            comm_run_o[c]        <= 1'b0;
         end else begin
            tx_req_o[c]          <= cy_tx && !(|busy_src_i[c]); // RQ8
            rx_read_done_o[c]    <= cy_rd;
            mode_switch_req_o[c] <= y_q[c*CH_STRIDE+Y_MODE_REQ];
            comm_run_o[c]        <= module_accessible_q && !(|busy_src_i[c]); // RQ8
         end
      end
   end

   // ----------------------------------------------------------------
   // Flash status
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         flash_rd_q     <= 1'b0;
         flash_wr_q     <= 1'b0;
         flash_rd_req_o <= 1'b0;
         flash_wr_req_o <= 1'b0;
      end else begin
         flash_rd_req_o <= y_q[Y_FLASH_RD];
         flash_wr_req_o <= y_q[Y_FLASH_WR];
         if (flash_rd_done_i && !flash_by_instr_i) begin
            flash_rd_q <= 1'b1; // RQ11
         end else if (!y_q[Y_FLASH_RD]) begin
            flash_rd_q <= 1'b0;
         end
         if (flash_wr_done_i && !flash_by_instr_i) begin
            flash_wr_q <= 1'b1; // RQ11
         end else if (!y_q[Y_FLASH_WR]) begin
            flash_wr_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupts: rising edges of status bits, write one to clear
   // ----------------------------------------------------------------
   always_comb begin
      irq_ev                = '0;
      irq_ev[IRQ_BCAST]     = broadcast_i[0] && !bcast_q[0];
      irq_ev[IRQ_BCAST+1]   = broadcast_i[1] && !bcast_q[1];
      irq_ev[IRQ_RESTORE]   = (rst_state_q == RST_RUN) && (rst_cnt_q == RESTORE_LAST);
      irq_ev[IRQ_READY]     = !module_accessible_q && (ready_cnt_q == READY_LAST);
      irq_ev[IRQ_WDT]       = watchdog_fault_condition_i && !watchdog_fault_q;
      irq_ev[IRQ_RX]        = rx_data_i[0] && !rx_req_q[0];
      irq_ev[IRQ_RX+1]      = rx_data_i[1] && !rx_req_q[1];
   end

   // Set wins over a simultaneous clear so no event is lost
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         irq_st_q <= '0;
         irq_o    <= 1'b0;
      end else begin
         if (ap_wr_q && ap_addr_q == IRQ_STATUS_OFS) begin
            irq_st_q <= (irq_st_q & ~hwdata_i[IRQ_W-1:0]) | irq_ev;
         end else begin
            irq_st_q <= irq_st_q | irq_ev;
         end
         irq_o <= |(irq_st_q & irq_mask_q);
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (srst_i);

   sequence s_restore_req;
      $rose(y_q[Y_RESTORE_REQ]) && rst_state_q == RST_IDLE;
   endsequence
   sequence s_restore_done;
      ##[1:RST_BND] default_restore_done_q;
   endsequence

   AST_RESTORE_HANDSHAKE: assert property (s_restore_req |-> s_restore_done) // RQ2
      else $error("restore done not raised after request");
   AST_READY_AT_COUNT: assert property ($rose(module_accessible_q) |-> // RQ4
      $past(ready_cnt_q) == READY_LAST)
      else $error("accessible rose at the wrong count");
   AST_READY_LOW_AFTER_RESET: assert property ( // RQ14
      $fell(srst_i) |-> !module_accessible_q && ready_cnt_q <= 32'h0000_0001)
      else $error("accessible not low after reset");
   AST_WDT_STICKY: assert property (watchdog_fault_condition_i |=> // RQ6
      watchdog_fault_q [*3])
      else $error("watchdog fault not raised and held");
   AST_BUSY_TRACKS: assert property ((|busy_src_i[0]) |=> busy_q[0] && !comm_run_o[0]) // RQ7
      else $error("channel busy not shown or traffic not stopped");
   AST_TX_SUSPEND: assert property (busy_q[1] && $past(busy_q[1]) |-> !tx_req_o[1]) // RQ8
      else $error("transmit request passed while busy");
   AST_TX_INSTR_QUIET: assert property (tx_ng_i[0] && tx_by_instr_i[0] && !tx_ng_q[0] // RQ11
      |=> !tx_ng_q[0])
      else $error("transmit completion set by instruction");
   AST_RX_REQ_SET: assert property (rx_data_i[1] |=> rx_req_q[1]) // RQ12
      else $error("receive read request not raised");
   AST_RESERVED_ZERO: assert property ((y_q & ~Y_WR_MASK) == 32'h0000_0000) // RQ9
      else $error("reserved output bit holds a value");
   AST_IRQ_LEVEL: assert property (irq_o == $past(|(irq_st_q & irq_mask_q)))
      else $error("interrupt output disagrees with status and mask");

endmodule // hsb_top

/* hsb_host_model.sv */
module hsb_host_model
   import hsb_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        hready_i,
   input  wire logic [31:0] hrdata_i,
   output logic             hsel_o,
   output logic [31:0]      haddr_o,
   output logic [1:0]       htrans_o,
   output logic             hwrite_o,
   output logic [2:0]       hsize_o,
   output logic [31:0]      hwdata_o
);
   timeunit 1ns;
   timeprecision 1ps;

   int timeouts = 0;

   initial begin
      hsel_o   = 1'b0;
      haddr_o  = 32'h0;
      htrans_o = 2'h0;
      hwrite_o = 1'b0;
      hsize_o  = 3'h2;
      hwdata_o = 32'h0;
   end

   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge core_clk_i);
      while (hready_i !== 1'b1 && n < 64) begin
         n++;
         @(posedge core_clk_i);
      end
      if (n >= 64) timeouts++;
   endtask

   // Idle bus lines carry the inverse of the last value, so stale data never looks valid
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rdata);
      @(posedge core_clk_i);
      hsel_o   <= 1'b1;
      haddr_o  <= a;
      htrans_o <= 2'h2;
      hwrite_o <= wr;
      wait_ready();
      hsel_o   <= 1'b0;
      htrans_o <= 2'h0;
      hwdata_o <= wr ? wd : ~hwdata_o;
      wait_ready();
      rdata = hrdata_i;
      haddr_o  <= ~a;
      hwdata_o <= ~wd;
   endtask

   // Nothing is requested until the module reports itself accessible
   task automatic wait_accessible();
      logic [31:0] v;
      int n;
      n = 0;
      xfer(1'b0, {24'h0, IN_BITS_OFS}, 32'h0, v);
      while (v[X_ACCESSIBLE] !== 1'b1 && n < 64) begin
         n++;
         xfer(1'b0, {24'h0, IN_BITS_OFS}, 32'h0, v);
      end
      if (n >= 64) timeouts++;
   endtask
endmodule // hsb_host_model

/* host_status_handshake_bits_tb.sv */
`define CHK(act, exp) begin num_checks++; if ((act) !== (exp)) begin n_errors++; \
   $display("ERROR t=%0t act=%h exp=%h", $time, act, exp); end end

module host_status_handshake_bits_tb
   import hsb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic core_clk_i, srst_i, hsel, hwrite, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata, d;
   logic [1:0] htrans, bcast, tx_ok, tx_ng, tx_instr, rx_data, rx_err, rx_rd;
   logic [2:0] hsize;
   logic [1:0][BUSY_SRC_W-1:0] busy;
   logic fl_rd, fl_wr, fl_instr, proto, wdt, fl_rd_req, fl_wr_req, rst_act;
   logic [1:0] tx_req, rx_done, mode_req, comm_run;
   int n_errors = 0;
   int num_checks = 0;

   hsb_top #(.READY_CYCLES(20), .RESTORE_CYCLES(4)) hsb_top_inst (
      .core_clk_i(core_clk_i), .srst_i(srst_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
      .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
      .irq_o(irq), .broadcast_i(bcast), .tx_ok_i(tx_ok), .tx_ng_i(tx_ng),
      .tx_by_instr_i(tx_instr), .rx_data_i(rx_data), .rx_err_i(rx_err),
      .rx_instr_read_i(rx_rd), .busy_src_i(busy), .flash_rd_done_i(fl_rd),
      .flash_wr_done_i(fl_wr), .flash_by_instr_i(fl_instr), .proto_ready_i(proto),
      .watchdog_fault_condition_i(wdt), .tx_req_o(tx_req), .rx_read_done_o(rx_done),
      .mode_switch_req_o(mode_req), .comm_run_o(comm_run), .flash_rd_req_o(fl_rd_req),
      .flash_wr_req_o(fl_wr_req), .restore_active_o(rst_act));

   hsb_host_model hsb_host_model_inst (
      .core_clk_i(core_clk_i), .hready_i(hreadyout), .hrdata_i(hrdata), .hsel_o(hsel),
      .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
      .hwdata_o(hwdata));

   initial begin
      core_clk_i = 1'b0;
      forever #2.5 core_clk_i = ~core_clk_i;
   end

   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] x;
      hsb_host_model_inst.xfer(1'b1, {24'h0, a}, v, x);
   endtask

   task automatic chk_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      hsb_host_model_inst.xfer(1'b0, {24'h0, a}, 32'h0, d);
      `CHK(d & m, e)
   endtask

   task automatic poll(input logic [7:0] a, input int b);
      int n;
      n = 0;
      hsb_host_model_inst.xfer(1'b0, {24'h0, a}, 32'h0, d);
      while (d[b] !== 1'b1 && n < 64) begin
         n++;
         hsb_host_model_inst.xfer(1'b0, {24'h0, a}, 32'h0, d);
      end
      `CHK(d[b], 1'b1)
   endtask

   task automatic finish_test();
      n_errors += hsb_host_model_inst.timeouts;
      $display("checks=%0d errors=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {srst_i, bcast, tx_ok, tx_ng, tx_instr, rx_data, rx_err, rx_rd} = {1'b1, 14'h0};
      {busy, fl_rd, fl_wr, fl_instr, proto, wdt} = '0;
      cyc(16);
      srst_i <= 1'b0;
      cyc(1);
      chk_rd(IN_BITS_OFS, 32'h4000_0000, 32'h0);
      chk_rd(OUT_BITS_OFS, 32'hffff_ffff, Y_RST);
      `CHK(hresp, 1'b0)
      chk_rd(IRQ_MASK_OFS, 32'h7f, {25'h0, MASK_RST});
      hsb_host_model_inst.wait_accessible();
      chk_rd(IRQ_STATUS_OFS, 32'h8, 32'h8);
      for (int c = 0; c < 2; c++) begin
         bcast <= 2'(1 << c);
         chk_rd(IN_BITS_OFS, 32'h0c00_0000, 32'(1 << (X_BCAST + c)));
         chk_rd(IRQ_STATUS_OFS, 32'(1 << c), 32'(1 << c));
      end
      proto <= 1'b1;
      chk_rd(IN_BITS_OFS, 32'h2000_0000, 32'h2000_0000);
      // Completion bits only hold while the paired request stays up
      wr(OUT_BITS_OFS, 32'h81);
      cyc(2);
      `CHK(tx_req, 2'b11)
      tx_ok <= 2'b11;
      cyc(1);
      tx_ok <= 2'b00;
      chk_rd(IN_BITS_OFS, 32'h81, 32'h81);
      tx_instr <= 2'b11;
      tx_ng <= 2'b11;
      cyc(1);
      tx_ng <= 2'b00;
      chk_rd(IN_BITS_OFS, 32'h102, 32'h0);
      for (int c = 0; c < 2; c++) begin
         for (int k = 0; k < BUSY_SRC_W; k++) begin
            busy[c][k] <= 1'b1;
            cyc(2);
            `CHK({comm_run[c], tx_req[c]}, 2'b00)
            chk_rd(IN_BITS_OFS, 32'(1 << (X_BUSY + 7 * c)), 32'(1 << (X_BUSY + 7 * c)));
            busy[c][k] <= 1'b0;
            cyc(3);
            `CHK({comm_run[c], tx_req[c]}, 2'b11)
         end
      end
      wr(OUT_BITS_OFS, 32'h0180_0000);
      cyc(2);
      chk_rd(IN_BITS_OFS, 32'h81, 32'h0);
      `CHK({fl_wr_req, fl_rd_req}, 2'b11)
      {fl_instr, fl_rd, fl_wr} <= 3'b111;
      cyc(1);
      {fl_rd, fl_wr} <= 2'b00;
      chk_rd(IN_BITS_OFS, 32'h0180_0000, 32'h0);
      fl_instr <= 1'b0;
      {fl_rd, fl_wr} <= 2'b11;
      cyc(1);
      {fl_rd, fl_wr} <= 2'b00;
      chk_rd(IN_BITS_OFS, 32'h0180_0000, 32'h0180_0000);
      {rx_data, rx_err} <= 4'hf;
      cyc(1);
      {rx_data, rx_err} <= 4'h0;
      chk_rd(IN_BITS_OFS, 32'h0c18, 32'h0c18);
      chk_rd(IRQ_STATUS_OFS, 32'h60, 32'h60);
      rx_rd <= 2'b11;
      cyc(1);
      rx_rd <= 2'b00;
      chk_rd(IN_BITS_OFS, 32'h0c18, 32'h0);
      rx_data <= 2'b11;
      cyc(1);
      rx_data <= 2'b00;
      wr(OUT_BITS_OFS, 32'h102);
      cyc(2);
      `CHK(rx_done, 2'b11)
      chk_rd(IN_BITS_OFS, 32'h0408, 32'h0);
      wr(OUT_BITS_OFS, 32'h1000_0000);
      cyc(3);
      `CHK(rst_act, 1'b1)
      poll(IN_BITS_OFS, X_RESTORE_DONE);
      `CHK(rst_act, 1'b0)
      chk_rd(IRQ_STATUS_OFS, 32'h4, 32'h4);
      wr(OUT_BITS_OFS, 32'h0);
      cyc(3);
      chk_rd(IN_BITS_OFS, 32'h1000_0000, 32'h0);
      // Host side keeps reserved and modem request bits low
      wr(OUT_BITS_OFS, Y_WR_MASK);
      chk_rd(OUT_BITS_OFS, 32'hffff_ffff, Y_WR_MASK);
      `CHK(mode_req, 2'b11)
      chk_rd(IN_BITS_OFS, 32'h007f_0000, 32'h0);
      wr(OUT_BITS_OFS, 32'h0);
      wr(8'h20, 32'hffff_ffff);
      chk_rd(8'h20, 32'hffff_ffff, 32'h0);
      cyc(12);
      wr(IRQ_STATUS_OFS, 32'h7f);
      chk_rd(IRQ_STATUS_OFS, 32'h7f, 32'h0);
      rx_data <= 2'b01;
      cyc(1);
      rx_data <= 2'b00;
      cyc(2);
      `CHK(irq, 1'b0)
      wr(IRQ_MASK_OFS, 32'h20);
      cyc(2);
      `CHK(irq, 1'b1)
      wr(IRQ_STATUS_OFS, 32'h20);
      cyc(2);
      `CHK(irq, 1'b0)
      chk_rd(IN_BITS_OFS, 32'h8000_0000, 32'h0);
      wdt <= 1'b1;
      cyc(1);
      wdt <= 1'b0;
      cyc(5);
      chk_rd(IN_BITS_OFS, 32'h8000_0000, 32'h8000_0000);
      chk_rd(IRQ_STATUS_OFS, 32'h10, 32'h10);
      finish_test();
   end
endmodule // host_status_handshake_bits_tb
